// ---- rtl/flash_ctl.sv ----
// module: on-chip flash read path, program/erase sequencer, boot loader
// Behaviour
// [RQ1] program one whole 32-byte page per operation
// [RQ2] erase one block per erase operation
// [RQ3] seven blocks: 12k, 16k, 28k, four 1k
// [RQ4] operations: program, erase, both verifies
// [RQ5] reads 16-bit wide, answered in two states
// [RQ6] mode sampled from straps during reset
// [RQ7] user mode reads only, no program/erase
// [RQ8] program/erase only in boot, user-program, writer
// [RQ9] erased bytes read back as ff
// [RQ10] boot mode erase covers whole array
// [RQ11] user-program mode erases whole blocks only
// [RQ12] software programs only erased blocks
// [RQ13] boot link detects 9600, 4800, 2400 bps
// [RQ14] hardware, software, error protection block operations
// [RQ15] software expects 10 ms program, 100 ms erase
// [RQ16] boot: start loader, check link, copy routine
// [RQ17] software checks enable pin before copying routine
// [RQ18] control writes need register select high
// [RQ19] low enable pin protects; flag mirrors pin
// [RQ20] program bit needs enable, permit, setup
// [RQ21] erase bit needs enable, permit, setup
// [RQ22] one operation at a time, others ignored
`timescale 1ns/1ns
module flash_ctl #(
   parameter int BIT_FAST = flash_ctl_pkg::CLK_HZ / flash_ctl_pkg::BAUD_FAST,
   parameter int BIT_MID = flash_ctl_pkg::CLK_HZ / flash_ctl_pkg::BAUD_MID,
   parameter int BIT_SLOW = flash_ctl_pkg::CLK_HZ / flash_ctl_pkg::BAUD_SLOW
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic mode_strap_a_in,
   input wire logic mode_strap_b_in,
   input wire logic hw_program_enable_input_in,
   input wire logic flash_register_select_in,
   input wire logic ctl_wr_in,
   input wire flash_ctl_pkg::ctl_bits_type ctl_data_in,
   input wire logic [flash_ctl_pkg::NUM_BLOCKS-1:0] block_sel_in,
   input wire logic page_wr_in,
   input wire logic [flash_ctl_pkg::ADDR_W-1:0] page_addr_in,
   input wire logic [7:0] page_data_in,
   input wire logic rd_req_in,
   input wire logic [flash_ctl_pkg::ADDR_W-1:0] rd_addr_in,
   input wire logic rd_byte_in,
   output logic [15:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic serial_rx_in,
   output logic [flash_ctl_pkg::LOADER_AW-1:0] boot_rom_addr_out,
   input wire logic [15:0] boot_rom_data_in,
   output logic loader_ram_we_out,
   output logic [flash_ctl_pkg::LOADER_AW-1:0] loader_ram_addr_out,
   output logic [15:0] loader_ram_data_out,
   output logic baud_lock_out,
   output logic [1:0] baud_sel_out,
   output flash_ctl_pkg::flash_status_type status_out
);
   localparam int NB = flash_ctl_pkg::NUM_BLOCKS;

   typedef enum {ENG_IDLE, ENG_PROG, ENG_ERASE, ENG_DONE} eng_state_type;
   typedef enum {
      BOOT_IDLE, BOOT_START, BOOT_CHECK, BOOT_COPY, BOOT_DONE
   } boot_state_type;

   logic [3:0] sync_a, sync_b;
   logic hw_sync, rx_sync;
   flash_ctl_pkg::op_mode_type mode, next_mode, strap_mode;
   flash_ctl_pkg::ctl_bits_type ctl, next_ctl;
   logic [NB-1:0] block_sel, next_sel;
   logic error, next_error;
   logic [3:0] ops, new_ops;
   logic op_allowed, erase_sel_ok, wr_ok;
   eng_state_type eng_state, next_eng_state;
   logic [15:0] eng_addr, next_eng_addr, eng_last, next_eng_last;
   logic [15:0] erase_first, erase_last;
   logic [7:0] mem [0:flash_ctl_pkg::ARRAY_BYTES-1];
   logic [7:0] page_buf [0:flash_ctl_pkg::PAGE_BYTES-1];
   logic [15:flash_ctl_pkg::PAGE_W] page_base;
   logic rd_q, rd_byte_q;
   logic [15:0] rd_addr_q, next_rd_data, word_addr;
   boot_state_type boot_state, next_boot_state;
   logic [flash_ctl_pkg::LOADER_AW-1:0] next_rom_addr;
   logic lock, next_ld_we;
   logic [1:0] sel;

   // pins are asynchronous; straps must settle before reset is released
   always_ff @(posedge clk_in) begin
      sync_a <= {serial_rx_in, hw_program_enable_input_in,
                 mode_strap_b_in, mode_strap_a_in};
      sync_b <= sync_a;
   end
   assign hw_sync = sync_b[2];
   assign rx_sync = sync_b[3];

   always_comb begin
      if (!sync_b[2]) begin
         strap_mode = flash_ctl_pkg::MODE_USER;
      end else if (sync_b[1]) begin
         strap_mode = flash_ctl_pkg::MODE_WRITER;
      end else if (sync_b[0]) begin
         strap_mode = flash_ctl_pkg::MODE_BOOT;
      end else begin
         strap_mode = flash_ctl_pkg::MODE_USER_PROG;
      end
      next_mode = rst_in ? strap_mode : mode; // RQ6
   end

   always_ff @(posedge clk_in) begin
      mode <= next_mode;
   end

   assign ops = {ctl.ev, ctl.pv, ctl.e, ctl.p}; // RQ4
   assign new_ops = {ctl_data_in.ev, ctl_data_in.pv,
                     ctl_data_in.e, ctl_data_in.p} & ~ops;
   assign op_allowed = (mode != flash_ctl_pkg::MODE_USER) && hw_sync
                       && !error; // RQ7 RQ8 RQ14
   assign erase_sel_ok = (mode == flash_ctl_pkg::MODE_BOOT)
                         || $onehot(block_sel); // RQ10 RQ11 RQ2
   assign wr_ok = ctl_wr_in && flash_register_select_in && hw_sync; // RQ18

   always_comb begin
      next_ctl = ctl;
      next_sel = block_sel;
      next_error = error;
      if (wr_ok) begin
         next_ctl.software_write_permit = ctl_data_in.software_write_permit;
         if (ctl.software_write_permit) begin
            next_ctl.program_setup_bit = ctl_data_in.program_setup_bit;
            next_ctl.erase_setup_bit = ctl_data_in.erase_setup_bit;
            next_sel = block_sel_in;
            // clearing an operation bit is always honoured
            next_ctl.ev = ctl.ev & ctl_data_in.ev;
            next_ctl.pv = ctl.pv & ctl_data_in.pv;
            next_ctl.e = ctl.e & ctl_data_in.e;
            next_ctl.p = ctl.p & ctl_data_in.p;
            if (op_allowed && ops == 4'h0 && $onehot(new_ops)) begin // RQ22
               next_ctl.ev = new_ops[3];
               next_ctl.pv = new_ops[2];
               next_ctl.e = new_ops[1] && ctl.erase_setup_bit && erase_sel_ok; // RQ21
               next_ctl.p = new_ops[0] && ctl.program_setup_bit; // RQ20
            end
         end
      end
      // pin dropped mid-operation: latch error until reset
      if ((ctl.p || ctl.e) && !hw_sync) begin
         next_error = 1'b1; // RQ14
      end
      if (next_error) begin
         next_ctl.ev = 1'b0;
         next_ctl.pv = 1'b0;
         next_ctl.e = 1'b0;
         next_ctl.p = 1'b0;
      end
      if (!hw_sync || !next_ctl.software_write_permit) begin // RQ19
         next_ctl = '0;
         next_sel = '0;
      end
   end

   always_comb begin
      erase_first = flash_ctl_pkg::ARRAY_FIRST;
      erase_last = flash_ctl_pkg::ARRAY_LAST; // RQ10
      if (mode != flash_ctl_pkg::MODE_BOOT) begin
         for (int i = 0; i < NB; i++) begin
            if (block_sel[i]) begin
               erase_first = flash_ctl_pkg::block_base(3'(i)); // RQ3
               erase_last = flash_ctl_pkg::block_last(3'(i));
            end
         end
      end
   end

   always_comb begin
      next_eng_state = eng_state;
      next_eng_addr = eng_addr;
      next_eng_last = eng_last;
      case (eng_state)
         ENG_IDLE: begin
            if (ctl.p) begin
               next_eng_state = ENG_PROG;
               next_eng_addr = {page_base, 5'h00}; // RQ1
               next_eng_last = {page_base, flash_ctl_pkg::PAGE_LAST};
            end else if (ctl.e) begin
               next_eng_state = ENG_ERASE; // RQ2
               next_eng_addr = erase_first;
               next_eng_last = erase_last;
            end
         end
         ENG_PROG, ENG_ERASE: begin
            if (!ctl.p && !ctl.e) begin
               next_eng_state = ENG_IDLE;
            end else if (eng_addr == eng_last) begin
               next_eng_state = ENG_DONE;
            end else begin
               next_eng_addr = eng_addr + 16'h0001;
            end
         end
         ENG_DONE: begin
            // one operation per setting of the bit
            if (!ctl.p && !ctl.e) begin
               next_eng_state = ENG_IDLE;
            end
         end
         default: begin
            next_eng_state = ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl <= '0;
         block_sel <= '0;
         error <= 1'b0;
         eng_state <= ENG_IDLE;
         eng_addr <= '0;
         eng_last <= '0;
      end else begin
         ctl <= next_ctl;
         block_sel <= next_sel;
         error <= next_error;
         eng_state <= next_eng_state;
         eng_addr <= next_eng_addr;
         eng_last <= next_eng_last;
      end
   end

   // programming can only clear bits, so unerased bytes end up corrupt
   always_ff @(posedge clk_in) begin
      if (eng_state == ENG_PROG) begin
         mem[eng_addr] <= mem[eng_addr] & page_buf[eng_addr[4:0]]; // RQ12
      end else if (eng_state == ENG_ERASE) begin
         mem[eng_addr] <= flash_ctl_pkg::ERASED_BYTE; // RQ9
      end
   end

   // unwritten page bytes stay ff and leave the array untouched
   always_ff @(posedge clk_in) begin
      if (rst_in || eng_state == ENG_DONE) begin
         for (int i = 0; i < flash_ctl_pkg::PAGE_BYTES; i++) begin
            page_buf[i] <= flash_ctl_pkg::ERASED_BYTE;
         end
      end else if (page_wr_in && eng_state == ENG_IDLE) begin
         page_buf[page_addr_in[4:0]] <= page_data_in; // RQ1
      end
      if (rst_in) begin
         page_base <= '0;
      end else if (page_wr_in && eng_state == ENG_IDLE) begin
         page_base <= page_addr_in[15:flash_ctl_pkg::PAGE_W];
      end
   end

   assign word_addr = {rd_addr_q[15:1], 1'b0};

   always_comb begin
      next_rd_data = 16'h0000;
      if (rd_addr_q <= flash_ctl_pkg::ARRAY_LAST) begin
         if (rd_byte_q) begin
            next_rd_data = {8'h00, mem[rd_addr_q]};
         end else begin
            next_rd_data = {mem[word_addr], mem[word_addr | 16'h0001]};
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_q <= 1'b0;
         rd_byte_q <= 1'b0;
         rd_addr_q <= '0;
         rd_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         rd_q <= rd_req_in;
         rd_byte_q <= rd_byte_in;
         rd_addr_q <= rd_addr_in;
         rd_valid_out <= rd_q; // RQ5
         rd_data_out <= rd_q ? next_rd_data : rd_data_out;
      end
   end

   baud_rate_detect #(
      .CNT_W(flash_ctl_pkg::BAUD_CNT_W),
      .BIT_FAST(BIT_FAST),
      .BIT_MID(BIT_MID),
      .BIT_SLOW(BIT_SLOW)
   ) u_baud (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .enable_in(boot_state == BOOT_CHECK),
      .rx_in(rx_sync),
      .lock_out(lock),
      .sel_out(sel)
   );

   // rom is read combinationally: data matches the address now driven
   always_comb begin
      next_boot_state = boot_state;
      next_rom_addr = boot_rom_addr_out;
      next_ld_we = 1'b0;
      case (boot_state)
         BOOT_IDLE: begin
            if (mode == flash_ctl_pkg::MODE_BOOT) begin
               next_boot_state = BOOT_START; // RQ16
            end
         end
         BOOT_START: begin
            next_boot_state = BOOT_CHECK;
         end
         BOOT_CHECK: begin
            next_rom_addr = '0;
            if (lock) begin
               next_boot_state = BOOT_COPY; // RQ16
            end
         end
         BOOT_COPY: begin
            next_ld_we = 1'b1;
            if (boot_rom_addr_out == flash_ctl_pkg::LOADER_LAST) begin
               next_boot_state = BOOT_DONE;
            end else begin
               next_rom_addr = boot_rom_addr_out + 1'b1;
            end
         end
         BOOT_DONE: begin
            next_boot_state = BOOT_DONE;
         end
         default: begin
            next_boot_state = BOOT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         boot_state <= BOOT_IDLE;
         boot_rom_addr_out <= '0;
         loader_ram_we_out <= 1'b0;
         loader_ram_addr_out <= '0;
         loader_ram_data_out <= '0;
         baud_lock_out <= 1'b0;
         baud_sel_out <= flash_ctl_pkg::BAUD_SEL_FAST;
         status_out <= '0;
      end else begin
         boot_state <= next_boot_state;
         boot_rom_addr_out <= next_rom_addr;
         loader_ram_we_out <= next_ld_we;
         loader_ram_addr_out <= boot_rom_addr_out;
         loader_ram_data_out <= boot_rom_data_in;
         baud_lock_out <= lock;
         baud_sel_out <= sel;
         status_out.hw_enable <= hw_sync; // RQ19
         status_out.ctl <= next_ctl;
         status_out.block_sel <= next_sel;
         status_out.error <= next_error;
         status_out.busy <= (next_eng_state == ENG_PROG)
                            || (next_eng_state == ENG_ERASE);
         status_out.done <= next_eng_state == ENG_DONE;
         status_out.mode <= mode;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_read_two_states: assert property (rd_req_in |-> ##2 rd_valid_out) // RQ5
      else $error("read not answered after two states");
   a_user_no_ops: assert property (mode == flash_ctl_pkg::MODE_USER
      |-> !ctl.p && !ctl.e && eng_state == ENG_IDLE) // RQ7
      else $error("program or erase active in user mode");
   a_hw_protect: assert property (!hw_sync |=> ctl == '0) // RQ19
      else $error("control bits kept while enable pin low");
   a_prog_gate: assert property ($rose(ctl.p)
      |-> $past(ctl.program_setup_bit) && $past(ctl.software_write_permit) && $past(hw_sync)) // RQ20
      else $error("program bit set without its conditions");
   a_erase_gate: assert property ($rose(ctl.e)
      |-> $past(ctl.erase_setup_bit) && $past(ctl.software_write_permit) && $past(hw_sync)) // RQ21
      else $error("erase bit set without its conditions");
   a_single_op: assert property ($onehot0(ops)) // RQ22
      else $error("two operations active together");
   a_prog_page: assert property (eng_state == ENG_PROG
      |-> eng_addr[15:5] == eng_last[15:5] && eng_last[4:0] == 5'h1f) // RQ1
      else $error("program runs outside one page");
   a_erase_ff: assert property (eng_state == ENG_ERASE
      |=> mem[$past(eng_addr)] == flash_ctl_pkg::ERASED_BYTE) // RQ9
      else $error("erased byte not ff");
   a_boot_whole: assert property ($rose(eng_state == ENG_ERASE)
      && mode == flash_ctl_pkg::MODE_BOOT
      |-> eng_addr == 16'h0000 && eng_last == 16'hefff) // RQ10
      else $error("boot erase not whole array");
   a_block_erase: assert property ($rose(eng_state == ENG_ERASE)
      && mode != flash_ctl_pkg::MODE_BOOT |-> $onehot(block_sel)) // RQ11
      else $error("block erase without a single block");
   a_mode_hold: assert property (##1 mode == $past(mode)) // RQ6
      else $error("mode changed outside reset");
   a_error_stops: assert property (error |-> ops == 4'h0) // RQ14
      else $error("operation active in error state");
   a_boot_copy: assert property (boot_state == BOOT_CHECK && lock
      |=> loader_ram_we_out == 1'b0 ##1 loader_ram_we_out) // RQ16
      else $error("loader copy not started after link check");
endmodule : flash_ctl

// ---- rtl/flash_ctl_pkg.sv ----
// package: constants and types of the flash program/erase controller
package flash_ctl_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int ADDR_W = 16;
   localparam int ARRAY_BYTES = 61440;
   localparam logic [15:0] ARRAY_FIRST = 16'h0000;
   localparam logic [15:0] ARRAY_LAST = 16'hefff;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;
   localparam logic [4:0] PAGE_LAST = 5'h1f;
   localparam int NUM_BLOCKS = 7;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int BAUD_FAST = 9600;
   localparam int BAUD_MID = 4800;
   localparam int BAUD_SLOW = 2400;
   localparam int SYNC_LOW_BITS = 9;
   localparam int BAUD_CNT_W = 20;
   localparam logic [1:0] BAUD_SEL_FAST = 2'h0;
   localparam logic [1:0] BAUD_SEL_MID = 2'h1;
   localparam logic [1:0] BAUD_SEL_SLOW = 2'h2;
   localparam int LOADER_AW = 6;
   localparam logic [5:0] LOADER_LAST = 6'h3f;

   typedef enum logic [1:0] {
      MODE_USER, MODE_USER_PROG, MODE_BOOT, MODE_WRITER
   } op_mode_type;

   typedef struct packed {
      logic software_write_permit;
      logic program_setup_bit;
      logic erase_setup_bit;
      logic ev;
      logic pv;
      logic e;
      logic p;
   } ctl_bits_type;

   typedef struct packed {
      logic hw_enable;
      ctl_bits_type ctl;
      logic [NUM_BLOCKS-1:0] block_sel;
      logic error;
      logic busy;
      logic done;
      op_mode_type mode;
   } flash_status_type;

   // erase block map: four 1k blocks, then 28k, 16k and 12k
   function automatic logic [15:0] block_base(input logic [2:0] idx);
      case (idx)
         3'h0: return 16'h0000;
         3'h1: return 16'h0400;
         3'h2: return 16'h0800;
         3'h3: return 16'h0c00;
         3'h4: return 16'h1000;
         3'h5: return 16'h8000;
         3'h6: return 16'hc000;
         default: return 16'h0000;
      endcase
   endfunction : block_base

   function automatic logic [15:0] block_last(input logic [2:0] idx);
      case (idx)
         3'h0: return 16'h03ff;
         3'h1: return 16'h07ff;
         3'h2: return 16'h0bff;
         3'h3: return 16'h0fff;
         3'h4: return 16'h7fff;
         3'h5: return 16'hbfff;
         3'h6: return 16'hefff;
         default: return 16'h0000;
      endcase
   endfunction : block_last
endpackage : flash_ctl_pkg

// ---- rtl/baud_rate_detect.sv ----
// module: bit rate detector for the boot serial link
`timescale 1ns/1ns
module baud_rate_detect #(
   parameter int CNT_W = flash_ctl_pkg::BAUD_CNT_W,
   parameter int BIT_FAST = 13020,
   parameter int BIT_MID = 26041,
   parameter int BIT_SLOW = 52083
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic enable_in,
   input wire logic rx_in,
   output logic lock_out,
   output logic [1:0] sel_out
);
   localparam int NB = flash_ctl_pkg::SYNC_LOW_BITS;
   // host sends a zero byte: start bit plus eight data bits stay low
   localparam logic [CNT_W-1:0] MIN_LOW = CNT_W'(NB * BIT_FAST / 2);
   localparam logic [CNT_W-1:0] SPLIT_HI =
      CNT_W'(NB * (BIT_FAST + BIT_MID) / 2);
   localparam logic [CNT_W-1:0] SPLIT_LO =
      CNT_W'(NB * (BIT_MID + BIT_SLOW) / 2);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   typedef enum {
      DET_IDLE, DET_WAIT_LOW, DET_MEASURE, DET_LOCKED
   } det_state_type;
   det_state_type state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic next_lock;
   logic [1:0] next_sel;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_lock = lock_out;
      next_sel = sel_out;
      case (state)
         DET_IDLE: begin
            // a line already low at enable gives no clean start edge
            if (enable_in && rx_in) begin
               next_state = DET_WAIT_LOW;
            end
         end
         DET_WAIT_LOW: begin
            next_cnt = '0;
            if (!rx_in) begin
               next_state = DET_MEASURE;
            end
         end
         DET_MEASURE: begin
            if (cnt != CNT_MAX) begin
               next_cnt = cnt + 1'b1;
            end
            if (rx_in) begin
               if (cnt < MIN_LOW) begin
                  next_state = DET_WAIT_LOW;
               end else begin
                  next_state = DET_LOCKED;
                  next_lock = 1'b1;
                  if (cnt < SPLIT_HI) begin // RQ13
                     next_sel = flash_ctl_pkg::BAUD_SEL_FAST;
                  end else if (cnt < SPLIT_LO) begin
                     next_sel = flash_ctl_pkg::BAUD_SEL_MID;
                  end else begin
                     next_sel = flash_ctl_pkg::BAUD_SEL_SLOW;
                  end
               end
            end
         end
         DET_LOCKED: begin
            next_lock = 1'b1;
         end
         default: begin
            next_state = DET_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= DET_IDLE;
         cnt <= '0;
         lock_out <= 1'b0;
         sel_out <= flash_ctl_pkg::BAUD_SEL_FAST;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         lock_out <= next_lock;
         sel_out <= next_sel;
      end
   end
endmodule : baud_rate_detect

// ---- sim/flash_host_model.sv ----
// far side model: built-in loader rom and boot serial host
`timescale 1ns/1ns
module flash_host_model #(
   parameter int BIT_CYC = 20
) (
   input wire logic clk_in,
   input wire logic [5:0] rom_addr_in,
   output logic [15:0] rom_data_out,
   input wire logic send_in,
   output logic rx_out
);
   // word pattern ties data to address so a slipped copy shows
   assign rom_data_out = {rom_addr_in, 4'h9, ~rom_addr_in};
   initial rx_out = 1'h1;
   // host sends one 0x00 byte: start and eight low bits, then idle high
   always begin
      @(posedge send_in);
      @(posedge clk_in);
      rx_out <= 1'h0;
      repeat (9 * BIT_CYC) @(posedge clk_in);
      rx_out <= 1'h1;
   end
endmodule : flash_host_model

// ---- sim/onchip_flash_program_erase_control_tb_top.sv ----
// self-checking bench of the flash program/erase controller
`timescale 1ns/1ns
module onchip_flash_program_erase_control_tb_top;
   logic clk_in = 1'h0, rst_in = 1'h1, strap_a = 1'h0, strap_b = 1'h0;
   logic pin_en = 1'h0, sel = 1'h1, ctl_wr = 1'h0, page_wr = 1'h0;
   logic rd_req = 1'h0, rd_byte = 1'h0, send = 1'h0, rx, ram_we, valid, lock;
   flash_ctl_pkg::ctl_bits_type ctl_data = '0;
   flash_ctl_pkg::flash_status_type st;
   logic [6:0] blk = 7'h00;
   logic [15:0] page_addr = 16'h0, rd_addr = 16'h0, rd_data, rom_data;
   logic [15:0] ram_data;
   logic [7:0] page_data = 8'h0;
   logic [5:0] rom_addr, ram_addr;
   logic [1:0] bsel;
   int error_cnt = 0, n_tests = 0, n_words = 0, i, cnt;
   // ordinary reads after one page program: {addr, byte, expected}
   logic [32:0] rows [7] = '{{16'h0000, 1'h0, 16'ha0a1},
      {16'h0001, 1'h0, 16'ha0a1}, {16'h0003, 1'h1, 16'h00a3},
      {16'h001e, 1'h0, 16'hbebf}, {16'h0020, 1'h1, 16'h00ff},
      {16'h03ff, 1'h1, 16'h00ff}, {16'hf000, 1'h0, 16'h0000}};

   initial forever #4 clk_in = ~clk_in;

   flash_ctl #(.BIT_FAST(20), .BIT_MID(40), .BIT_SLOW(80)) dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .mode_strap_a_in(strap_a),
      .mode_strap_b_in(strap_b), .hw_program_enable_input_in(pin_en),
      .flash_register_select_in(sel), .ctl_wr_in(ctl_wr),
      .ctl_data_in(ctl_data), .block_sel_in(blk), .page_wr_in(page_wr),
      .page_addr_in(page_addr), .page_data_in(page_data),
      .rd_req_in(rd_req), .rd_addr_in(rd_addr), .rd_byte_in(rd_byte),
      .rd_data_out(rd_data), .rd_valid_out(valid), .serial_rx_in(rx),
      .boot_rom_addr_out(rom_addr), .boot_rom_data_in(rom_data),
      .loader_ram_we_out(ram_we), .loader_ram_addr_out(ram_addr),
      .loader_ram_data_out(ram_data), .baud_lock_out(lock),
      .baud_sel_out(bsel), .status_out(st));

   flash_host_model #(.BIT_CYC(20)) host_u (.clk_in(clk_in),
      .rom_addr_in(rom_addr), .rom_data_out(rom_data), .send_in(send),
      .rx_out(rx));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         error_cnt++;
         print_verdict();
      end
   endtask : guard

   task automatic do_reset(input logic a, input logic b, input logic p);
      @(negedge clk_in);
      rst_in = 1'h1;
      strap_a = a;
      strap_b = b;
      pin_en = p;
      repeat (10) @(negedge clk_in);
      rst_in = 1'h0;
      // status shows the captured mode only one edge after release
      @(negedge clk_in);
   endtask : do_reset

   task automatic wr(input logic [6:0] bits, input logic [6:0] b);
      @(negedge clk_in);
      ctl_wr = 1'h1;
      ctl_data = bits;
      blk = b;
      @(negedge clk_in);
      ctl_wr = 1'h0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic b,
                     input logic [15:0] exp);
      @(negedge clk_in);
      rd_req = 1'h1;
      rd_addr = a;
      rd_byte = b;
      @(negedge clk_in);
      rd_req = 1'h0;
      check({15'h0, valid}, 16'h0);
      @(negedge clk_in);
      check({15'h0, valid}, 16'h1);
      check(rd_data, exp);
   endtask : rd

   task automatic wait_done;
      for (i = 0; i < 70000 && st.done !== 1'h1; i++) @(negedge clk_in);
      guard(i, 70000);
   endtask : wait_done

   // loader copy: one word a cycle, address in order, rom data intact
   // sampled on the falling edge, clear of the edge that launches it
   always @(negedge clk_in) begin
      if (ram_we === 1'h1) begin
         check({10'h0, ram_addr}, 16'(n_words));
         check(ram_data, {6'(n_words), 4'h9, ~6'(n_words)});
         n_words++;
      end
   end

   initial begin
      // pin low: user mode, control writes dead
      do_reset(1'h0, 1'h0, 1'h0);
      check({14'h0, st.mode}, {14'h0, flash_ctl_pkg::MODE_USER});
      wr(7'h40, 7'h00);
      check({8'h0, st.hw_enable, st.ctl}, 16'h0);
      // pin raised after reset: mode stays user, program refused
      pin_en = 1'h1;
      repeat (4) @(negedge clk_in);
      check({15'h0, st.hw_enable}, 16'h1);
      wr(7'h40, 7'h00);
      wr(7'h60, 7'h00);
      wr(7'h61, 7'h00);
      check({15'h0, st.ctl.p}, 16'h0);
      // user-program mode: erase block 0, then program one page
      do_reset(1'h0, 1'h0, 1'h1);
      check({14'h0, st.mode}, {14'h0, flash_ctl_pkg::MODE_USER_PROG});
      wr(7'h40, 7'h00);
      wr(7'h50, 7'h03);
      wr(7'h52, 7'h03);
      check({15'h0, st.ctl.e}, 16'h0);
      wr(7'h50, 7'h01);
      wr(7'h52, 7'h01);
      wait_done();
      wr(7'h40, 7'h00);
      for (i = 0; i < 32; i++) begin
         @(negedge clk_in);
         page_wr = 1'h1;
         page_addr = 16'(i);
         page_data = 8'ha0 + 8'(i);
      end
      @(negedge clk_in);
      page_wr = 1'h0;
      wr(7'h60, 7'h00);
      wr(7'h61, 7'h00);
      cnt = 0;
      for (i = 0; i < 100 && st.done !== 1'h1; i++) begin
         @(negedge clk_in);
         cnt += (st.busy === 1'h1) ? 1 : 0;
      end
      guard(i, 100);
      check(16'(cnt), 16'h0020);
      wr(7'h65, 7'h00);
      check({15'h0, st.ctl.pv}, 16'h0);
      @(negedge clk_in);
      sel = 1'h0;
      wr(7'h00, 7'h00);
      sel = 1'h1;
      check({15'h0, st.ctl.software_write_permit}, 16'h1);
      wr(7'h40, 7'h00);
      for (int r = 0; r < 7; r++) begin
         rd(rows[r][32:17], rows[r][16], rows[r][15:0]);
      end
      wr(7'h44, 7'h00);
      check({9'h0, st.ctl}, 16'h0044);
      wr(7'h40, 7'h00);
      wr(7'h48, 7'h00);
      check({9'h0, st.ctl}, 16'h0048);
      // pin dropped during a block erase latches the error state
      wr(7'h40, 7'h00);
      wr(7'h50, 7'h01);
      wr(7'h52, 7'h01);
      pin_en = 1'h0;
      repeat (5) @(negedge clk_in);
      check({8'h0, st.hw_enable, st.ctl}, 16'h0);
      check({15'h0, st.error}, 16'h1);
      // boot mode: rate lock, loader copy, whole-array erase
      do_reset(1'h1, 1'h0, 1'h1);
      check({14'h0, st.mode}, {14'h0, flash_ctl_pkg::MODE_BOOT});
      send = 1'h1;
      @(negedge clk_in);
      send = 1'h0;
      for (i = 0; i < 3000 && lock !== 1'h1; i++) @(negedge clk_in);
      guard(i, 3000);
      check({14'h0, bsel}, {14'h0, flash_ctl_pkg::BAUD_SEL_FAST});
      for (i = 0; i < 500 && n_words < 64; i++) @(negedge clk_in);
      guard(i, 500);
      repeat (4) @(negedge clk_in);
      check(16'(n_words), 16'h0040);
      wr(7'h40, 7'h00);
      wr(7'h50, 7'h00);
      wr(7'h52, 7'h00);
      wait_done();
      rd(16'hefff, 1'h1, 16'h00ff);
      rd(16'h0000, 1'h0, 16'hffff);
      do_reset(1'h0, 1'h1, 1'h1);
      check({14'h0, st.mode}, {14'h0, flash_ctl_pkg::MODE_WRITER});
      print_verdict();
   end
endmodule : onchip_flash_program_erase_control_tb_top
